// ==== hdl/phys_region_access_guard.sv ====
/*
  Physical region access guard: per-hart permission checker with its
  machine-level register port. Assumes requests hold until granted and that
  the pipeline flushes younger work on a fault.
*/
`default_nettype none
module phys_region_access_guard (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [11:0] reg_num,
  input wire logic [31:0] reg_wdata,
  input wire logic [1:0] reg_priv,
  input wire logic wide_mode,
  output logic [31:0] reg_rdata,
  output logic reg_illegal,
  // Privilege state
  input wire logic [1:0] cur_priv,
  input wire logic modify_privilege_bit,
  input wire logic [1:0] saved_prev_privilege,
  // Access request
  input wire logic acc_valid,
  input wire logic [1:0] acc_kind,
  input wire logic acc_walk,
  input wire logic acc_committed,
  input wire logic [33:0] acc_addr,
  input wire logic [3:0] acc_size,
  input wire logic acc_side_effect,
  // Access answer
  output logic acc_ready,
  output logic mem_valid,
  output logic [33:0] mem_addr,
  output logic [3:0] mem_size,
  output logic [1:0] mem_kind,
  output logic fault_valid,
  output logic [1:0] fault_cause,
  output logic prefetch_valid,
  output logic [33:0] prefetch_addr
);
  region_cfg_if cif ();

  region_entry_store u_store (
    .clk(clk),
    .rst_b(rst_b),
    .cif(cif)
  );

  function automatic logic [7:0] legal_cfg(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    r[6:5] = 2'h0;
    if (!v[region_guard_pkg::cfg_read_bit] && v[region_guard_pkg::cfg_write_bit]) begin
      r[region_guard_pkg::cfg_write_bit] = 1'b0; // (R17)
    end
    return r;
  endfunction

  function automatic logic [1:0] mode_of(input logic [7:0] c);
    return c[region_guard_pkg::cfg_mode_lsb +: 2];
  endfunction

  // Register decode
  wire logic is_machine = (reg_priv == 2'h3);
  wire logic in_pack = (reg_num >= region_guard_pkg::cfg_pack_base) &&
                       (reg_num <= region_guard_pkg::cfg_pack_last);
  wire logic in_addr = (reg_num >= region_guard_pkg::addr_base) &&
                       (reg_num <= region_guard_pkg::addr_last);
  wire logic [3:0] pack_idx = reg_num[3:0];
  wire logic [5:0] addr_idx = 6'(reg_num - region_guard_pkg::addr_base);
  wire logic odd_wide = wide_mode && pack_idx[0]; // (R13)
  wire logic reg_bad = reg_req &&
                       (!is_machine || !(in_pack || in_addr) || (in_pack && odd_wide)); // (R11)
  wire logic reg_ok = reg_req && !reg_bad;

  // Which entry byte a lane of a packed register maps to (R12) (R22) (R21)
  logic [6:0] lane_entry [8];
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      lane_entry[b] = {1'b0, pack_idx, 2'h0} + 7'(b);
    end
  end

  // Read data, configuration bytes stay where they are across width changes
  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (in_pack) begin
      for (int b = 0; b < 4; b++) begin
        if (lane_entry[b] < 7'(region_guard_pkg::num_entries)) begin
          rdata_next[b*8 +: 8] = cif.cfg[lane_entry[b][3:0]];
        end
      end
    end else if (in_addr && addr_idx < 6'(region_guard_pkg::num_entries)) begin
      rdata_next = cif.addr[addr_idx[3:0]]; // (R14) (R15)
    end
  end

  // Lock check per entry: own lock, or next entry locked as top of range (R24) (R8)
  wire logic [3:0] aidx = addr_idx[3:0];
  wire logic addr_exists = addr_idx < 6'(region_guard_pkg::num_entries); // (R10)
  wire logic own_lock = cif.cfg[aidx][region_guard_pkg::cfg_lock_bit];
  wire logic next_lock = (aidx != 4'hf) &&
                         cif.cfg[4'(aidx + 4'h1)][region_guard_pkg::cfg_lock_bit] &&
                         (mode_of(cif.cfg[4'(aidx + 4'h1)]) ==
                          region_guard_pkg::mode_top_of_range);

  // One config byte written per cycle: the lowest unlocked lane of this pack whose value changes
  logic cfg_we;
  logic [3:0] cfg_widx;
  logic [7:0] cfg_wdata;
  always_comb begin
    cfg_we = 1'b0;
    cfg_widx = 4'h0;
    cfg_wdata = 8'h00;
    if (reg_ok && reg_we && in_pack && pack_idx < 4'h4) begin
      for (int b = 3; b >= 0; b--) begin
        if (!cif.cfg[lane_entry[b][3:0]][region_guard_pkg::cfg_lock_bit] &&
            cif.cfg[lane_entry[b][3:0]] != legal_cfg(reg_wdata[b*8 +: 8])) begin
          cfg_we = 1'b1; // (R24)
          cfg_widx = lane_entry[b][3:0];
          cfg_wdata = legal_cfg(reg_wdata[b*8 +: 8]); // (R11)
        end
      end
    end
  end

  // Multi-byte pack writes land one lane per cycle; pipeline holds the write
  wire logic addr_we = reg_ok && reg_we && in_addr && addr_exists && !own_lock && !next_lock;
  assign cif.wr_cfg = cfg_we;
  assign cif.wr_addr = addr_we && !cfg_we;
  assign cif.wr_index = cfg_we ? cfg_widx : aidx;
  assign cif.wr_cfg_data = cfg_wdata;
  assign cif.wr_addr_data = reg_wdata & 32'hffff_ffff; // (R15)
  wire logic reg_busy = cfg_we;

  // Effective privilege (R6) (R7)
  wire logic modify_privilege_bit_data = (cur_priv == 2'h3) && modify_privilege_bit && (acc_kind != 2'h0);
  wire logic [1:0] eff_priv = acc_walk ? 2'h1 : (modify_privilege_bit_data ? saved_prev_privilege : cur_priv);
  wire logic eff_machine = (eff_priv == 2'h3);

  // Byte range of the access, granule units of four bytes
  wire logic [33:0] acc_last = acc_addr + 34'(acc_size) - 34'h1;
  wire logic [31:0] lo_g = acc_addr[33:2];
  wire logic [31:0] hi_g = acc_last[33:2];

  // Match logic per entry (R23)
  logic [15:0] any_hit;
  logic [15:0] all_hit;
  always_comb begin
    logic [31:0] base;
    logic [31:0] mask;
    logic [31:0] bot;
    base = 32'h0;
    mask = 32'h0;
    bot = 32'h0;
    for (int i = 0; i < 16; i++) begin
      bot = (i == 0) ? 32'h0 : cif.addr[(i == 0) ? 0 : i - 1];
      mask = ~((cif.addr[i] ^ (cif.addr[i] + 32'h1)));
      base = cif.addr[i];
      case (mode_of(cif.cfg[i]))
        region_guard_pkg::mode_top_of_range: begin
          any_hit[i] = (hi_g >= bot) && (lo_g < base) && (bot < base);
          all_hit[i] = (lo_g >= bot) && (hi_g < base);
        end
        region_guard_pkg::mode_four_byte: begin
          any_hit[i] = (lo_g <= base) && (hi_g >= base);
          all_hit[i] = (lo_g == base) && (hi_g == base);
        end
        region_guard_pkg::mode_pow2: begin
          any_hit[i] = ((lo_g & mask) <= (base & mask)) && ((hi_g & mask) >= (base & mask));
          all_hit[i] = ((lo_g & mask) == (base & mask)) && ((hi_g & mask) == (base & mask));
        end
        default: begin
          any_hit[i] = 1'b0;
          all_hit[i] = 1'b0;
        end
      endcase
    end
  end

  // Priority resolution (R25) (R26) (R16)
  logic allow;
  always_comb begin
    logic found;
    logic [7:0] c;
    found = 1'b0;
    c = 8'h00;
    allow = eff_machine; // (R26)
    for (int i = 15; i >= 0; i--) begin
      if (any_hit[i]) begin
        found = 1'b1;
        c = cif.cfg[i];
        if (!all_hit[i]) begin
          allow = 1'b0; // (R25)
        end else if (eff_machine && !c[region_guard_pkg::cfg_lock_bit]) begin
          allow = 1'b1; // (R24)
        end else begin
          case (acc_kind)
            2'h0: allow = c[region_guard_pkg::cfg_exec_bit]; // (R18)
            2'h1: allow = c[region_guard_pkg::cfg_read_bit]; // (R19)
            2'h2: allow = c[region_guard_pkg::cfg_write_bit]; // (R20)
            default: allow = 1'b0;
          endcase
        end
      end
    end
    if (!found && !eff_machine) begin
      allow = 1'b0; // (R26)
    end
  end

  // Side-effect policy (R1) (R2) (R3)
  wire logic misaligned = (acc_size != 4'h0) && ((acc_addr[3:0] & (acc_size - 4'h1)) != 4'h0);
  wire logic side_block = acc_side_effect && misaligned; // (R2)
  wire logic may_issue = !acc_side_effect || acc_committed; // (R1) (R3)
  wire logic take = acc_valid && may_issue && !reg_busy; // (R27)
  assign acc_ready = take;

  // Extra fetch block, wraps at the top of the address space (R4) (R5)
  wire logic [33:0] next_block = {acc_addr[33:region_guard_pkg::block_shift] +
                                  28'h1, 6'h00};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_valid <= 1'b0;
      mem_addr <= 34'h0;
      mem_size <= 4'h0;
      mem_kind <= 2'h0;
      fault_valid <= 1'b0;
      fault_cause <= 2'h0;
      prefetch_valid <= 1'b0;
      prefetch_addr <= 34'h0;
      reg_rdata <= 32'h0;
      reg_illegal <= 1'b0;
    end else begin
      mem_valid <= take && allow && !side_block; // (R9) (R27)
      mem_addr <= acc_addr;
      mem_size <= acc_size;
      mem_kind <= acc_kind;
      fault_valid <= take && (!allow || side_block); // (R9)
      fault_cause <= (acc_kind == 2'h0) ? 2'h1 : ((acc_kind == 2'h1) ? 2'h2 : 2'h3);
      prefetch_valid <= take && allow && acc_committed && (acc_kind == 2'h0) &&
                        acc_side_effect; // (R4)
      prefetch_addr <= next_block;
      reg_rdata <= reg_ok ? rdata_next : 32'h0;
      reg_illegal <= reg_bad; // (R13)
    end
  end
endmodule // phys_region_access_guard
`default_nettype wire

// ==== hdl/region_cfg_if.sv ====
/*
  Carrier between the guard top and its entry store.
  Assumes one writer per cycle.
*/
`default_nettype none
interface region_cfg_if;
  logic wr_cfg;
  logic wr_addr;
  logic [3:0] wr_index;
  logic [7:0] wr_cfg_data;
  logic [31:0] wr_addr_data;
  logic [7:0] cfg [16];
  logic [31:0] addr [16];
  modport store (input wr_cfg, wr_addr, wr_index, wr_cfg_data, wr_addr_data,
                 output cfg, addr);
  modport user (output wr_cfg, wr_addr, wr_index, wr_cfg_data, wr_addr_data,
                input cfg, addr);
endinterface : region_cfg_if
`default_nettype wire

// ==== hdl/region_entry_store.sv ====
/*
  Entry store: configuration bytes and address registers for every entry.
  Assumes the top has already legalised the data and applied locks.
*/
`default_nettype none
module region_entry_store (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Entry port
  region_cfg_if.store cif
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 16; i++) begin
        cif.cfg[i] <= region_guard_pkg::cfg_reset;
        cif.addr[i] <= region_guard_pkg::addr_reset;
      end
    end else begin
      if (cif.wr_cfg) begin
        cif.cfg[cif.wr_index] <= cif.wr_cfg_data;
      end
      if (cif.wr_addr) begin
        cif.addr[cif.wr_index] <= cif.wr_addr_data;
      end
    end
  end
endmodule // region_entry_store
`default_nettype wire

// ==== hdl/region_guard_pkg.sv ====
/*
  Constants, field layouts and types for the physical region access guard.
  Assumes a hart pipeline that presents one access request and a machine-level
  register port on the same hart clock.
*/
// Function
// (R1) Side-effecting regions never receive speculative or duplicated accesses.
// (R2) Misaligned access to side-effecting region raises access fault, not misalign.
// (R3) Implicit side-effect reads only when committed; aligned block widening allowed.
// (R4) Committed fetch may also read next aligned block, wrapping around.
// (R5) Extra-read block size chosen here, not above smallest page size.
// (R6) Check every supervisor or user access, including modified-privilege machine data.
// (R7) Page-table walk accesses checked as supervisor level.
// (R8) Machine-level enforced entries lock their registers until hart reset.
// (R9) Every violation gives a precise fault with nothing younger taking effect.
// (R10) Each entry has a config byte and address register; sixteen entries built.
// (R11) Fields accept any write, keep legal values; machine-level access only.
// (R12) Narrow width: sixteen packed config registers, four bytes each, entry order.
// (R13) Wide width: only even packed registers exist; odd ones are illegal.
// (R14) Address register holds physical address bits 33 to 2.
// (R15) Unimplemented address bits ignore writes and read legal values.
// (R16) Read, write, execute bits grant their access type when set.
// (R17) Read clear with write set is reserved and never retained.
// (R18) Fetch without execute permission raises instruction access fault.
// (R19) Load or load-reserved without read permission raises load access fault.
// (R20) Store, store-conditional or atomic op without write permission raises store fault.
// (R21) Config bytes keep their value when the machine register width changes.
// (R22) Wide width: entries 8 to 15 sit in packed register two; here it reads and writes only entries 8 to 11.
// (R23) Match mode: 0 off, 1 top of range, 2 four-byte, 3 power-of-two.
// (R24) Lock bit ignores entry writes until reset and enforces machine accesses.
// (R25) Lowest matching entry decides; partial coverage fails the access.
// (R26) No match: machine access passes; others fail when entries exist.
// (R27) Check is evaluated before commit so a fault suppresses the access.
`default_nettype none
package region_guard_pkg;
  localparam int unsigned num_entries = 16;
  localparam int unsigned addr_reg_width = 32;
  localparam int unsigned phys_addr_width = 34;
  localparam int unsigned impl_addr_bits = 32;
  localparam int unsigned block_shift = 6;
  localparam int unsigned cfg_read_bit = 0;
  localparam int unsigned cfg_write_bit = 1;
  localparam int unsigned cfg_exec_bit = 2;
  localparam int unsigned cfg_mode_lsb = 3;
  localparam int unsigned cfg_lock_bit = 7;
  localparam logic [7:0] cfg_reset = 8'h00;
  localparam logic [31:0] addr_reset = 32'h0000_0000;
  localparam logic [11:0] cfg_pack_base = 12'h3a0;
  localparam logic [11:0] cfg_pack_last = 12'h3af;
  localparam logic [11:0] addr_base = 12'h3b0;
  localparam logic [11:0] addr_last = 12'h3ef;
  localparam logic [1:0] mode_off = 2'h0;
  localparam logic [1:0] mode_top_of_range = 2'h1;
  localparam logic [1:0] mode_four_byte = 2'h2;
  localparam logic [1:0] mode_pow2 = 2'h3;
  typedef enum logic [1:0] {priv_user, priv_super, priv_rsvd, priv_machine} priv_t;
  typedef enum logic [1:0] {acc_fetch, acc_load, acc_store} access_kind_t;
  typedef enum logic [1:0] {fault_none, fault_instr, fault_load, fault_store} fault_t;
endpackage : region_guard_pkg
`default_nettype wire

// ==== test/hart_model.sv ====
/*
  Hart pipeline model: one access at a time, held until taken or eight cycles pass.
  Assumes the bench calls issue from a single process.
*/
`default_nettype none
module hart_model (
  // Clock
  input wire logic clk,
  // Answer
  input wire logic acc_ready,
  input wire logic mem_valid,
  input wire logic fault_valid,
  input wire logic [1:0] fault_cause,
  input wire logic prefetch_valid,
  // Request
  output logic acc_valid = 1'b0,
  output logic [1:0] acc_kind = 2'h0,
  output logic acc_committed = 1'b0,
  output logic [33:0] acc_addr = 34'h0,
  output logic [3:0] acc_size = 4'h4,
  output logic acc_side_effect = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic issue(input logic [1:0] k, input logic [33:0] a, input logic [3:0] s,
                       input logic se, input logic cm, output logic [3:0] res);
    logic taken;
    int n;
    taken = 1'b0;
    n = 0;
    res = 4'hf;
    @(posedge clk);
    #1 acc_valid = 1'b1;
    acc_kind = k;
    acc_addr = a;
    acc_size = s;
    acc_side_effect = se;
    acc_committed = cm;
    // Ready is combinational, so it is sampled just before the edge
    while (!taken && n < 8) begin
      #2 taken = acc_ready;
      @(posedge clk);
      #1 n++;
    end
    // The cause lines run free while no fault is signalled, so mask them
    if (taken) res = {prefetch_valid, mem_valid, fault_valid ? fault_cause : 2'h0};
    acc_valid = 1'b0;
    // Released lines must not keep showing the old address
    acc_addr = ~acc_addr;
  endtask
endmodule // hart_model
`default_nettype wire

// ==== test/phys_region_access_guard_tb_top.sv ====
/*
  Bench for the region guard: register port driven here, accesses by the
  hart model. Assumes a 4 ns clock and inputs moved 1 ns after each edge.
*/
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module phys_region_access_guard_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_req = 1'b0, reg_we = 1'b0, wide_mode = 1'b0, ill;
  logic [11:0] reg_num = 12'h000;
  logic [31:0] reg_wdata = 32'h0, rd, reg_rdata;
  logic [1:0] reg_priv = 2'h3, cur_priv = 2'h1, saved_prev_privilege = 2'h0;
  logic modify_privilege_bit = 1'b0, acc_walk = 1'b0, reg_illegal;
  logic acc_valid, acc_committed, acc_side_effect, acc_ready, mem_valid;
  logic fault_valid, prefetch_valid;
  logic [1:0] acc_kind, fault_cause, mem_kind;
  logic [33:0] acc_addr, mem_addr, prefetch_addr;
  logic [3:0] acc_size, mem_size, res;
  int mismatches = 0, n_checks = 0;
  always #2 clk = ~clk;
  phys_region_access_guard dut (.*);
  hart_model hart (.*);
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic reg_op(input logic [11:0] n, input logic w, input logic [31:0] d);
    @(posedge clk);
    #1 reg_req = 1'b1;
    reg_we = w;
    reg_num = n;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_req = 1'b0;
    rd = reg_rdata;
    ill = reg_illegal;
  endtask
  task automatic acc(input logic [1:0] k, input logic [33:0] a, input logic [3:0] s,
                     input logic se, input logic cm, input logic [3:0] e);
    hart.issue(k, a, s, se, cm, res);
    `CHK(res, e)
    if (e == 4'h4 || e == 4'hc) `CHK(mem_kind, k)
    if (e == 4'h4 || e == 4'hc) `CHK(mem_size, s)
    // A request that never got taken means the guard hung
    if (res === 4'hf && e !== 4'hf) wrap_up();
  endtask
  task automatic t_regs();
    reg_op(12'h3a0, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    reg_op(12'h3a0, 1'b1, 32'h62);
    reg_op(12'h3a0, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    reg_op(12'h3b0, 1'b1, 32'h100);
    reg_op(12'h3b0, 1'b0, 32'h0);
    `CHK(rd, 32'h100)
    reg_op(12'h3f0, 1'b0, 32'h0);
    `CHK(ill, 1'b1)
    reg_priv = 2'h1;
    reg_op(12'h3b0, 1'b1, 32'h0);
    `CHK(ill, 1'b1)
    reg_priv = 2'h3;
    wide_mode = 1'b1;
    reg_op(12'h3a1, 1'b0, 32'h0);
    `CHK(ill, 1'b1)
    reg_op(12'h3a2, 1'b1, 32'h1);
    wide_mode = 1'b0;
    reg_op(12'h3a2, 1'b0, 32'h0);
    `CHK(rd, 32'h1)
    $display("test regs done");
  endtask
  task automatic t_perm();
    reg_op(12'h3a0, 1'b1, 32'h0000_0009);
    reg_op(12'h3b1, 1'b1, 32'h200);
    reg_op(12'h3a0, 1'b1, 32'h0000_0c09);
    acc(2'h1, 34'h10, 4'h4, 1'b0, 1'b1, 4'h4);
    acc(2'h2, 34'h10, 4'h4, 1'b0, 1'b1, 4'h3);
    acc(2'h0, 34'h10, 4'h4, 1'b0, 1'b1, 4'h1);
    acc(2'h0, 34'h500, 4'h4, 1'b0, 1'b1, 4'h4);
    acc(2'h1, 34'h500, 4'h8, 1'b0, 1'b1, 4'h2);
    acc(2'h1, 34'h3fc, 4'h8, 1'b0, 1'b1, 4'h2);
    acc(2'h1, 34'h800, 4'h4, 1'b0, 1'b1, 4'h2);
    cur_priv = 2'h3;
    acc(2'h1, 34'h800, 4'h4, 1'b0, 1'b1, 4'h4);
    modify_privilege_bit = 1'b1;
    saved_prev_privilege = 2'h1;
    acc(2'h1, 34'h800, 4'h4, 1'b0, 1'b1, 4'h2);
    acc(2'h0, 34'h800, 4'h4, 1'b0, 1'b1, 4'h4);
    modify_privilege_bit = 1'b0;
    acc_walk = 1'b1;
    acc(2'h1, 34'h800, 4'h4, 1'b0, 1'b1, 4'h2);
    acc_walk = 1'b0;
    cur_priv = 2'h1;
    $display("test perm done");
  endtask
  task automatic t_side();
    acc(2'h1, 34'h20, 4'h4, 1'b1, 1'b0, 4'hf);
    acc(2'h1, 34'h20, 4'h4, 1'b1, 1'b1, 4'h4);
    acc(2'h1, 34'h11, 4'h4, 1'b1, 1'b1, 4'h2);
    acc(2'h0, 34'h5c0, 4'h4, 1'b1, 1'b1, 4'hc);
    `CHK(prefetch_addr, 34'h600)
    cur_priv = 2'h3;
    acc(2'h0, 34'h3_ffff_ffc0, 4'h4, 1'b1, 1'b1, 4'hc);
    `CHK(prefetch_addr, 34'h0)
    cur_priv = 2'h1;
    $display("test side done");
  endtask
  task automatic t_match();
    reg_op(12'h3b4, 1'b1, 32'h500);
    reg_op(12'h3b5, 1'b1, 32'h401);
    reg_op(12'h3a1, 1'b1, 32'h11);
    reg_op(12'h3a1, 1'b1, 32'h1b11);
    reg_op(12'h3a1, 1'b0, 32'h0);
    `CHK(rd, 32'h1b11)
    acc(2'h1, 34'h1400, 4'h4, 1'b0, 1'b1, 4'h4);
    acc(2'h2, 34'h1400, 4'h4, 1'b0, 1'b1, 4'h3);
    acc(2'h1, 34'h1404, 4'h4, 1'b0, 1'b1, 4'h2);
    acc(2'h2, 34'h1008, 4'h4, 1'b0, 1'b1, 4'h4);
    acc(2'h1, 34'h100c, 4'h8, 1'b0, 1'b1, 4'h2);
    $display("test match done");
  endtask
  task automatic t_lock();
    reg_op(12'h3b2, 1'b1, 32'h300);
    reg_op(12'h3a0, 1'b1, 32'h0088_0c09);
    cur_priv = 2'h3;
    acc(2'h1, 34'h900, 4'h4, 1'b0, 1'b1, 4'h2);
    cur_priv = 2'h1;
    reg_op(12'h3b2, 1'b1, 32'h0);
    reg_op(12'h3b2, 1'b0, 32'h0);
    `CHK(rd, 32'h300)
    reg_op(12'h3b1, 1'b1, 32'h250);
    reg_op(12'h3b1, 1'b0, 32'h0);
    `CHK(rd, 32'h200)
    reg_op(12'h3a0, 1'b1, 32'h0000_0c09);
    reg_op(12'h3a0, 1'b0, 32'h0);
    `CHK(rd, 32'h0088_0c09)
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    reg_op(12'h3a0, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    $display("test lock done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    t_regs();
    t_perm();
    t_side();
    t_match();
    t_lock();
    wrap_up();
  end
endmodule // phys_region_access_guard_tb_top
`default_nettype wire

// ==== test/region_guard_asserts.sv ====
/*
  Checker for the region guard's access answers and register refusals.
  Assumes it is bound to the guard top and sees only its ports.
*/
`default_nettype none
module region_guard_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic reg_req,
  input wire logic [11:0] reg_num,
  input wire logic [1:0] reg_priv,
  input wire logic wide_mode,
  input wire logic reg_illegal,
  // Access
  input wire logic acc_valid,
  input wire logic [1:0] acc_kind,
  input wire logic acc_committed,
  input wire logic [33:0] acc_addr,
  input wire logic [3:0] acc_size,
  input wire logic acc_side_effect,
  input wire logic acc_ready,
  input wire logic mem_valid,
  input wire logic [33:0] mem_addr,
  input wire logic fault_valid,
  input wire logic [1:0] fault_cause,
  input wire logic prefetch_valid,
  input wire logic [33:0] prefetch_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic take = acc_valid && acc_ready;
  wire logic mis = (acc_addr[3:0] & (acc_size - 4'h1)) != 4'h0;
  wire logic pf_ok = take && acc_kind == 2'h0 && acc_committed && acc_side_effect;
  wire logic [27:0] blk = acc_addr[33:6];
  wire logic [33:0] nxt = {blk + 28'h1, 6'h00};
  wire logic odd_pack = (reg_num[11:4] == 8'h3a) && reg_num[0];
  AST_ONE_ANSWER: assert property (take |=> mem_valid != fault_valid)
    else $error("access taken without exactly one answer");
  AST_NO_SPEC: assert property (acc_valid && acc_side_effect && !acc_committed |-> !acc_ready)
    else $error("speculative side-effect access taken");
  AST_NO_EXTRA: assert property (mem_valid || fault_valid |-> $past(take))
    else $error("answer without a taken access");
  AST_MISALIGN: assert property (take && acc_side_effect && mis |=> fault_valid)
    else $error("misaligned side-effect access not faulted");
  AST_CAUSE: assert property (fault_valid |-> fault_cause == $past(acc_kind) + 2'h1)
    else $error("fault cause does not follow access kind");
  AST_ISSUE_ADDR: assert property (mem_valid |-> mem_addr == $past(acc_addr))
    else $error("issued address differs from request");
  AST_PF_NEXT: assert property (prefetch_valid |-> mem_valid && prefetch_addr == $past(nxt))
    else $error("extra read not at next block");
  AST_PF_CAUSE: assert property (prefetch_valid |-> $past(pf_ok))
    else $error("extra read without committed side-effect fetch");
  AST_PRIV_ONLY: assert property (reg_req && reg_priv != 2'h3 |=> reg_illegal)
    else $error("non-machine register access not refused");
  AST_ODD_PACK: assert property (reg_req && wide_mode && odd_pack |=> reg_illegal)
    else $error("odd pack access in wide layout not refused");
  cover property (take ##1 fault_valid);
  cover property (prefetch_valid);
  cover property (reg_illegal);
endmodule // region_guard_asserts
bind phys_region_access_guard region_guard_asserts chk (.*);
`default_nettype wire
